//--- odsi_pkg.sv
// Purpose: Shared constants for the octal converter serial write interface
// Assumes: CORE_CLK at 25 MHz, link clock sampled as a plain input
// Notes:   Command layout of the 16-bit frame and edge counts live here
package odsi_pkg;
  localparam int          FRAME_BITS     = 16;          // Bits in one frame
  localparam int          CODE_BITS      = 10;          // Converter resolution
  localparam int          CHAN_COUNT     = 8;           // Independent channels
  localparam int          CHAN_BITS      = 3;           // Channel select width
  localparam int          CMD_MSB        = 15;          // Top bit of frame
  localparam int          CMD_NIB_LSB    = 12;          // Low bit of top nibble
  localparam int          ADDR_MSB       = 14;          // Channel field top
  localparam int          ADDR_LSB       = 12;          // Channel field bottom
  localparam int          DATA_MSB       = 11;          // Code field top
  localparam int          CODE_LSB       = 2;           // Code sits left aligned in 11:0
  localparam logic [3:0]  NIB_REG_ONLY   = 4'h8;        // Select register-only mode
  localparam logic [3:0]  NIB_WRITE_THRU = 4'h9;        // Select write-through mode
  localparam logic [7:0]  EDGE_ABORT     = 8'h0E;       // Fewer than this many edges aborts
  localparam logic [7:0]  EDGE_FRAME     = 8'h10;       // Edges in a complete frame
  localparam logic [7:0]  EDGE_CHAIN_HI  = 8'h0F;       // Chain output rises on this edge
  localparam logic [7:0]  EDGE_CHAIN_ON  = 8'h11;       // Past this edge the stream passes
  localparam logic [7:0]  EDGE_MAX       = 8'hFF;       // Counter saturation
  localparam logic [9:0]  CODE_RESET     = 10'h000;     // Channel code after reset
  localparam int          FIFO_DEPTH     = 8;           // Command buffer depth
endpackage : odsi_pkg

//--- odsi_fifo.sv
// Purpose: Small synchronous FIFO carrying captured frames to the executor
// Assumes: One clock, asynchronous active-high reset
// Notes:   Read data come out of a register; full and empty are exact
module odsi_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];     // Storage words
  logic [AW-1:0]    wr_ptr_ff;       // Next slot to fill
  logic [AW-1:0]    rd_ptr_ff;       // Next slot to drain
  logic [AW:0]      count_ff;        // Words held, head included
  logic             push;
  logic             pop;

  // Head word sits in the output register, so out_valid means count nonzero
  // Full compares the whole count, not a pointer-width copy that wraps to zero
  assign in_ready  = (count_ff != (AW+1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage write, no reset needed on data
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Registered read port, loads the next memory word on a pop, or the incoming word when it becomes the head
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_data <= '0;
    end else if (push && (count_ff == '0 || (pop && count_ff == (AW+1)'(1)))) begin
      out_data <= in_data;
    end else if (pop) begin
      out_data <= mem[(rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1];
    end
  end
endmodule : odsi_fifo

//--- odsi_core.sv
// Purpose: Serial write port and channel code registers of an octal converter
// Assumes: Link clock, frame sync and data come from outside and are synchronised
// Notes:   Frames are captured on link falling edges and executed on sync rise
//
// Contract
// - Valid frame: sixteen falling clock edges, sync low
// - Shift data in on each falling edge
// - Sixteenth falling edge captures last bit
// - Sync rise executes complete frame command
// - Early sync rise aborts, discards bits
// - Past edge 17, input passes to output; here DOUT already carries the first bit from fall 16
// - Codes are unsigned binary 0 to 1023
// - Eight channels, each own 10-bit register
// - Mode decides immediate or deferred output update; register-only writes never reach CHAN_OUT here
// - Wake begins at the ending sync rise
// - Nibble 1000 register-only, 1001 write-through, persistent
// - Power-up starts in register-only mode
// - Top bit zero writes selected channel code
// - Chain output: low 14, high 15th, then data
module odsi_core
  import odsi_pkg::*;
(
  // Clock and reset
  input  wire logic                                        CORE_CLK,
  input  wire logic                                        RESET,
  // Serial link from the host
  input  wire logic                                        SCLK,
  input  wire logic                                        SYNC_N,
  input  wire logic                                        DIN,
  // Chain output
  output logic                                             DOUT,
  // Converter side
  output logic [odsi_pkg::CHAN_COUNT*odsi_pkg::CODE_BITS-1:0] CHAN_REG,
  output logic [odsi_pkg::CHAN_COUNT*odsi_pkg::CODE_BITS-1:0] CHAN_OUT,
  output logic [odsi_pkg::CHAN_COUNT-1:0]                  CHAN_WAKE,
  output logic                                             WRITE_THROUGH,
  output logic                                             FRAME_DROP
);
  import odsi_pkg::*;

  typedef enum logic [1:0] {
    ODSI_IDLE  = 2'b00,  // Sync high, waiting
    ODSI_SHIFT = 2'b01,  // Sync low, bits arriving
    ODSI_DONE  = 2'b11   // Sync rose, deciding
  } odsi_state_t;

  // Synchronisers: first stage read only by second stage
  logic                  sclk_meta_ff;   // Link clock stage 1
  logic                  sync_meta_ff;   // Sync stage 1
  logic                  din_meta_ff;    // Data stage 1
  logic [1:0]            sclk_sync_ff;   // Index 0 synced, 1 previous
  logic [1:0]            sync_sync_ff;   // Sync stage 2 and its history
  logic [0:0]            din_sync_ff;    // Data stage 2, no edge needed
  logic                  sclk_fall;      // Falling link edge seen
  logic                  sync_fall;      // Frame start
  logic                  sync_rise;      // Frame end

  odsi_state_t           state_ff;       // Frame state
  odsi_state_t           nxt_state;
  logic [FRAME_BITS-1:0] shift_ff;       // Input shift register
  logic [7:0]            edge_cnt_ff;    // Falling edges this frame
  logic [FRAME_BITS-2:0] chain_ff;       // Delay line, fifteen falls deep
  logic                  fifo_in_ready;  // Executor can take a frame
  logic                  fifo_out_valid;
  logic [FRAME_BITS-1:0] fifo_out_data;
  logic                  push_ff;        // Frame offered to FIFO
  logic [FRAME_BITS-1:0] push_data_ff;
  logic [CODE_BITS-1:0]  code_reg_ff [CHAN_COUNT];  // Channel registers
  logic [CODE_BITS-1:0]  code_out_ff [CHAN_COUNT];  // Converter inputs
  logic                  mode_wt_ff;     // High in write-through mode

  // Extract the code field; low two bits of the field are don't care
  function automatic logic [CODE_BITS-1:0] frame_code(input logic [FRAME_BITS-1:0] f);
    frame_code = f[DATA_MSB:CODE_LSB];
  endfunction : frame_code

  // Two-stage synchronisers, then an edge history stage
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      sclk_meta_ff <= 1'b1;                // Idle high, no false edge after reset
      sync_meta_ff <= 1'b1;
      din_meta_ff  <= 1'b0;
      sclk_sync_ff <= 2'h3;
      sync_sync_ff <= 2'h3;
      din_sync_ff  <= 1'h0;
    end else begin
      sclk_meta_ff <= SCLK;
      sync_meta_ff <= SYNC_N;
      din_meta_ff  <= DIN;
      sclk_sync_ff <= {sclk_sync_ff[0], sclk_meta_ff};
      sync_sync_ff <= {sync_sync_ff[0], sync_meta_ff};
      din_sync_ff  <= din_meta_ff;
    end
  end

  // Edges come from synced stage 0 versus its previous value
  assign sclk_fall = sclk_sync_ff[1] && !sclk_sync_ff[0];
  assign sync_fall = sync_sync_ff[1] && !sync_sync_ff[0];
  assign sync_rise = !sync_sync_ff[1] && sync_sync_ff[0];

  // Frame state decision
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ODSI_IDLE: begin
        if (sync_fall) begin
          nxt_state = ODSI_SHIFT;
        end
      end
      ODSI_SHIFT: begin
        if (sync_rise) begin
          nxt_state = ODSI_DONE;
        end
      end
      ODSI_DONE: begin
        nxt_state = ODSI_IDLE;
      end
      default: begin
        nxt_state = ODSI_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      state_ff <= ODSI_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Shift register and edge count; clock fall with sync still low only
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      shift_ff    <= '0;
      edge_cnt_ff <= 8'h00;
    end else if (state_ff == ODSI_IDLE && sync_fall) begin
      edge_cnt_ff <= 8'h00;                               // Fresh frame, count cleared; old shift bits stay until shifted out
    end else if (state_ff == ODSI_SHIFT && sclk_fall && !sync_sync_ff[0]) begin
      if (edge_cnt_ff < EDGE_FRAME) begin
        shift_ff <= {shift_ff[FRAME_BITS-2:0], din_sync_ff[0]};
      end
      if (edge_cnt_ff != EDGE_MAX) begin
        edge_cnt_ff <= edge_cnt_ff + 8'h01;
      end
    end
  end

  // Chain output: low, high on edge 15, then the first bits received
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      chain_ff <= '0;
      DOUT     <= 1'b0;
    end else if (state_ff == ODSI_IDLE && sync_fall) begin
      chain_ff <= '0;
      DOUT     <= 1'b0;
    end else if (state_ff == ODSI_SHIFT && sclk_fall && !sync_sync_ff[0]) begin
      chain_ff <= {chain_ff[FRAME_BITS-3:0], din_sync_ff[0]};
      if (edge_cnt_ff + 8'h01 < EDGE_CHAIN_HI) begin
        DOUT <= 1'b0;
      end else if (edge_cnt_ff + 8'h01 == EDGE_CHAIN_HI) begin
        DOUT <= 1'b1;
      end else begin
        DOUT <= chain_ff[FRAME_BITS-2];                  // First bit leaves on fall 16
      end
    end
  end

  // Hand a complete frame to the FIFO on sync rise; short or long ones drop
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      push_ff      <= 1'b0;
      push_data_ff <= '0;
      FRAME_DROP   <= 1'b0;
    end else begin
      push_ff    <= 1'b0;
      FRAME_DROP <= 1'b0;
      if (state_ff == ODSI_SHIFT && sync_rise) begin
        if (edge_cnt_ff == EDGE_FRAME && fifo_in_ready) begin
          push_ff      <= 1'b1;
          push_data_ff <= shift_ff;
        end else begin
          FRAME_DROP <= 1'b1;
        end
      end
    end
  end

  odsi_fifo #(
    .WIDTH (FRAME_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CORE_CLK),
    .rst       (RESET),
    .in_valid  (push_ff),
    .in_ready  (fifo_in_ready),
    .in_data   (push_data_ff),
    .out_valid (fifo_out_valid),
    .out_ready (1'b1),
    .out_data  (fifo_out_data)
  );

  // Command execution: mode change or channel write
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      mode_wt_ff <= 1'b0;
      CHAN_WAKE  <= '0;
      for (int i = 0; i < CHAN_COUNT; i++) begin
        code_reg_ff[i] <= CODE_RESET;
        code_out_ff[i] <= CODE_RESET;
      end
    end else begin
      CHAN_WAKE <= '0;
      if (fifo_out_valid) begin
        if (!fifo_out_data[CMD_MSB]) begin
          code_reg_ff[fifo_out_data[ADDR_MSB:ADDR_LSB]] <= frame_code(fifo_out_data);
          if (mode_wt_ff) begin
            code_out_ff[fifo_out_data[ADDR_MSB:ADDR_LSB]] <= frame_code(fifo_out_data);
            CHAN_WAKE[fifo_out_data[ADDR_MSB:ADDR_LSB]] <= 1'b1;
          end
        end else if (fifo_out_data[CMD_MSB:CMD_NIB_LSB] == NIB_REG_ONLY) begin
          mode_wt_ff <= 1'b0;
        end else if (fifo_out_data[CMD_MSB:CMD_NIB_LSB] == NIB_WRITE_THRU) begin
          mode_wt_ff <= 1'b1;
        end
      end
    end
  end

  // Flatten registers onto ports
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      CHAN_REG      <= '0;
      CHAN_OUT      <= '0;
      WRITE_THROUGH <= 1'b0;
    end else begin
      WRITE_THROUGH <= mode_wt_ff;
      for (int i = 0; i < CHAN_COUNT; i++) begin
        CHAN_REG[i*CODE_BITS +: CODE_BITS] <= code_reg_ff[i];
        CHAN_OUT[i*CODE_BITS +: CODE_BITS] <= code_out_ff[i];
      end
    end
  end
endmodule : odsi_core

//--- odsi_monitor.sv
// Purpose: Port checks of the octal converter serial write interface
// Assumes: Link pins change on CORE_CLK rising edges
// Notes:   Fall count and bit history are rebuilt here from SCLK and DIN
module odsi_monitor
  import odsi_pkg::*;
(
  // Clock and reset
  input wire logic                                             CORE_CLK,
  input wire logic                                             RESET,
  // Serial link
  input wire logic                                             SCLK,
  input wire logic                                             SYNC_N,
  input wire logic                                             DIN,
  input wire logic                                             DOUT,
  // Converter side
  input wire logic [odsi_pkg::CHAN_COUNT*odsi_pkg::CODE_BITS-1:0] CHAN_REG,
  input wire logic [odsi_pkg::CHAN_COUNT*odsi_pkg::CODE_BITS-1:0] CHAN_OUT,
  input wire logic [odsi_pkg::CHAN_COUNT-1:0]                  CHAN_WAKE,
  input wire logic                                             WRITE_THROUGH,
  input wire logic                                             FRAME_DROP
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        sclk_q_ff; // Link clock one cycle ago
  logic [7:0]  falls_ff;  // Falls so far in this frame
  logic [15:0] hist_ff;   // Bits taken at falls, newest at bit 0
  logic        fall;      // Link clock fall inside a frame
  assign fall = sclk_q_ff & ~SCLK & ~SYNC_N;
  // Keep the last link clock level to spot falls
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) sclk_q_ff <= 1'b1;
    else sclk_q_ff <= SCLK;
  end
  // Count falls; saturate so a long chain cannot wrap
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) falls_ff <= 8'h00;
    else if (SYNC_N) falls_ff <= 8'h00;
    else if (fall && falls_ff != 8'hFF) falls_ff <= falls_ff + 8'h01;
  end
  // Shift in the data bit of every fall
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) hist_ff <= 16'h0000;
    else if (fall) hist_ff <= {hist_ff[14:0], DIN};
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  // At a fall the design has not yet seen it, so DOUT shows the previous one
  chain_low_a: assert property (fall && falls_ff >= 8'h01 && falls_ff <= 8'h0E |-> !DOUT)
    else $error("chain output high too early");
  chain_mark_a: assert property (fall && falls_ff == 8'h0F |-> DOUT)
    else $error("chain marker missing");
  chain_data_a: assert property (fall && falls_ff >= 8'h10 && falls_ff <= 8'h1F |-> DOUT == hist_ff[15])
    else $error("chain data wrong");
  reg_quiet_a: assert property ($changed(CHAN_REG) |-> SYNC_N)
    else $error("channel register moved inside a frame");
  mode_quiet_a: assert property ($changed(WRITE_THROUGH) |-> SYNC_N)
    else $error("mode moved inside a frame");
  out_gate_a: assert property ($changed(CHAN_OUT) |-> WRITE_THROUGH)
    else $error("output moved in register-only mode");
  wake_pulse_a: assert property (|CHAN_WAKE |-> WRITE_THROUGH && $onehot(CHAN_WAKE) ##1 CHAN_WAKE == '0)
    else $error("wake pulse wrong");
  drop_pulse_a: assert property (FRAME_DROP |-> SYNC_N ##1 !FRAME_DROP)
    else $error("drop pulse wrong");
  reset_zero_a: assert property (disable iff (1'b0) RESET && $past(RESET) |-> CHAN_REG == '0 && CHAN_OUT == '0 && !WRITE_THROUGH)
    else $error("state not clear in reset");
  // Main scenarios
  drop_c: cover property (FRAME_DROP);
  wake_c: cover property (|CHAN_WAKE);
  chain_c: cover property (falls_ff == 8'h20);
endmodule : odsi_monitor

//--- odsi_host_model.sv
// Purpose: Host controller that sends frames on the serial link
// Assumes: Link clock period is eight core clocks
// Notes:   Link clock stands high between frames
module odsi_host_model (
  // Core clock paces the host
  input wire logic clk,
  // Link pins
  output logic     sclk,
  output logic     sync_n,
  output logic     din
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle levels
  initial begin
    sclk = 1'b1;
    sync_n = 1'b1;
    din = 1'b0;
  end
  // One frame of a given number of falls, bits sent MSB first and repeated past 16
  task automatic send_frame(input logic [15:0] w, input int falls);
    int i;
    sync_n <= 1'b0;
    repeat (4) @(posedge clk);  // Keep sync away from a clock fall
    for (i = 0; i < falls; i++) begin
      din <= w[15 - (i % 16)];
      repeat (4) @(posedge clk);
      sclk <= 1'b0;
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
    end
    repeat (2) @(posedge clk);
    sync_n <= 1'b1;             // After the last fall of the frame
    din <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : send_frame
endmodule : odsi_host_model

//--- odsi_tb.sv
// Purpose: Self-checking bench of the octal converter serial write port
// Assumes: Update lands within sixteen core clocks of the sync rise
// Notes:   Random frames come from a fixed seed
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import odsi_pkg::*;
  logic        CORE_CLK;             // Core clock
  logic        RESET;                // Reset
  logic        SCLK, SYNC_N, DIN;    // Link from host model
  logic        DOUT, FRAME_DROP;     // Chain out and drop pulse
  logic        WRITE_THROUGH, exp_wt;
  logic [79:0] CHAN_REG, CHAN_OUT, exp_reg, exp_out;
  logic [7:0]  CHAN_WAKE;
  int          err_count, num_checks, drops, exp_drops, wakes, exp_wakes, i;
  integer      seed;
  logic [15:0] w;
  odsi_host_model host_u (.clk(CORE_CLK), .sclk(SCLK), .sync_n(SYNC_N), .din(DIN));
  odsi_core dut_u (.CORE_CLK(CORE_CLK), .RESET(RESET), .SCLK(SCLK), .SYNC_N(SYNC_N), .DIN(DIN),
    .DOUT(DOUT), .CHAN_REG(CHAN_REG), .CHAN_OUT(CHAN_OUT), .CHAN_WAKE(CHAN_WAKE),
    .WRITE_THROUGH(WRITE_THROUGH), .FRAME_DROP(FRAME_DROP));
  always #20 CORE_CLK = ~CORE_CLK;
  // Count drop pulses away from the launching edge
  always @(negedge CORE_CLK) if (FRAME_DROP === 1'b1) drops++;
  always @(negedge CORE_CLK) if ((|CHAN_WAKE) === 1'b1) wakes++;
  task automatic chk_bit(input string name, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s exp %b got %b", name, exp, got);
    end
  endtask : chk_bit
  task automatic chk_word(input string name, input logic [79:0] exp, input logic [79:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", name, exp, got);
    end
  endtask : chk_word
  task automatic chk_count(input string name, input int exp, input int got);
    num_checks++;
    if (got != exp) begin
      err_count++;
      $display("CHECK FAILED %s exp %0d got %0d", name, exp, got);
    end
  endtask : chk_count
  // Expected effect of a complete frame
  task automatic predict(input logic [15:0] f);
    if (f[CMD_MSB] == 1'b0) begin
      exp_reg[f[ADDR_MSB:ADDR_LSB]*CODE_BITS +: CODE_BITS] = f[DATA_MSB:CODE_LSB];
      if (exp_wt) begin
        exp_out[f[ADDR_MSB:ADDR_LSB]*CODE_BITS +: CODE_BITS] = f[DATA_MSB:CODE_LSB];
        exp_wakes++;
      end
    end else if (f[CMD_MSB:CMD_NIB_LSB] == NIB_WRITE_THRU) exp_wt = 1'b1;
    else if (f[CMD_MSB:CMD_NIB_LSB] == NIB_REG_ONLY) exp_wt = 1'b0;
  endtask : predict
  // Anything but sixteen falls must be dropped
  task automatic frame(input logic [15:0] f, input int n);
    host_u.send_frame(f, n);
    if (n == FRAME_BITS) predict(f);
    else exp_drops++;
    repeat (8) @(posedge CORE_CLK);
  endtask : frame
  task automatic check_all;
    chk_word("CHAN_REG", exp_reg, CHAN_REG);
    chk_word("CHAN_OUT", exp_out, CHAN_OUT);
    chk_bit("WRITE_THROUGH", exp_wt, WRITE_THROUGH);
    chk_count("FRAME_DROP", exp_drops, drops);
    chk_count("CHAN_WAKE", exp_wakes, wakes);
  endtask : check_all
  task automatic do_reset;
    RESET <= 1'b1;
    exp_reg = '0;
    exp_out = '0;
    exp_wt = 1'b0;
    repeat (3) @(posedge CORE_CLK);
    RESET <= 1'b0;
    repeat (4) @(posedge CORE_CLK);
  endtask : do_reset
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  // Hang guard
  initial begin
    repeat (30000) @(posedge CORE_CLK);
    err_count++;
    tally_and_finish;
  end
  // Main sequence
  initial begin
    CORE_CLK = 1'b0;
    RESET = 1'b1;
    seed = 32'haa35;
    {err_count, num_checks, drops, exp_drops, wakes, exp_wakes} = '0;
    do_reset;
    check_all;
    frame(16'h0FFC, 16);        // Channel A full scale
    frame(16'h7000, 16);        // Channel H zero
    check_all;
    for (i = 0; i < 32; i++) begin
      w = 16'($random(seed));
      if (w[15]) w[15:12] = w[12] ? NIB_WRITE_THRU : NIB_REG_ONLY;
      frame(w, 16);
      check_all;
    end
    frame(16'h1155, 14);        // Early sync rise
    check_all;
    frame(16'h2AA8, 48);        // Long frame passes data on
    check_all;
    frame(16'h9000, 16);        // Write-through mode
    frame(16'h5FFC, 16);        // Channel F updates at once
    check_all;
    frame(16'h8000, 16);        // Register-only mode
    frame(16'h3004, 16);        // Channel D register only
    check_all;
    do_reset;
    check_all;
    frame(16'h1008, 16);        // First frame after a mid-run reset
    check_all;
    tally_and_finish;
  end
endmodule : tb
bind odsi_core odsi_monitor mon_u (.CORE_CLK(CORE_CLK), .RESET(RESET), .SCLK(SCLK), .SYNC_N(SYNC_N),
  .DIN(DIN), .DOUT(DOUT), .CHAN_REG(CHAN_REG), .CHAN_OUT(CHAN_OUT), .CHAN_WAKE(CHAN_WAKE),
  .WRITE_THROUGH(WRITE_THROUGH), .FRAME_DROP(FRAME_DROP));
